// >>> esh_defs.svh
`ifndef ESH_DEFS_SVH
`define ESH_DEFS_SVH
// Register byte offsets.
`define ESH_CTRL 5'h00
`define ESH_ADDR 5'h04
`define ESH_WDLO 5'h08
`define ESH_WDHI 5'h0c
`define ESH_CMD 5'h10
`define ESH_STAT 5'h14
`define ESH_RDLO 5'h18
`define ESH_RDHI 5'h1c
// Control field positions and reset value.
`define ESH_C_RL 1:0
`define ESH_C_WL 3:2
`define ESH_C_BLK 4
`define ESH_C_KHZ 6:5
`define ESH_C_SRC 8:7
`define ESH_CTRL_RST 9'h000
// Command field positions.
`define ESH_K_OP 3:0
`define ESH_K_DRS 4
`define ESH_K_DWS 5
`define ESH_K_CE 7:6
`define ESH_K_BE 15:8
// Timing in interface clock periods and core cycles.
`define ESH_CAS_LAT 4'h3
`define ESH_RUN_LAST 4'h7
`define ESH_FLOAT_E 2'h2
`define ESH_RESUME_E 2'h2
`define ESH_DIV4 3'h3
`define ESH_DIV6 3'h5
`endif

// >>> esh_pkg.sv
`default_nettype none
package esh_pkg;
  typedef enum logic [5:0] {
    H_IDLE = 6'h01, H_WAIT = 6'h02, H_FLOAT = 6'h04,
    H_HELD = 6'h08, H_RESUME = 6'h10, H_REGRANT = 6'h20
  } esh_hold_e;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_ROW_ACTIVATE_CMD = 4'h1, OP_READ = 4'h2, OP_WRITE = 4'h3,
    OP_PRECHARGE_ALL_CMD = 4'h4, OP_BANK_DEACTIVATE_CMD = 4'h5, OP_AUTO_REFRESH_CMD = 4'h6, OP_MRS = 4'h7,
    OP_SRE = 4'h8, OP_SRX = 4'h9
  } esh_op_e;
  typedef struct packed {
    logic sdram_row_strobe_n;
    logic sdram_col_strobe_n;
    logic sdram_write_strobe_n;
  } esh_strobe_s;
endpackage
`default_nettype wire

// >>> esh_top.sv
// Our own choices: the address map and register access over Avalon-MM.
`include "esh_defs.svh"
`default_nettype none
module esh_top (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic BUS_YIELD_REQ_N,
  output logic BUS_YIELD_GRANT_N,
  output logic EXT_BUS_OE,
  output logic [3:0] CHIP_ENABLE_N,
  output logic [7:0] BYTE_ENABLE_N,
  output logic [22:3] EXT_ADDR_BUS,
  input wire logic [63:0] EXT_DATA_BUS_I,
  output logic [63:0] EXT_DATA_BUS_O,
  output logic EXT_DATA_BUS_OE,
  output esh_pkg::esh_strobe_s SDRAM_STROBES,
  output logic SDRAM_CLK_ENABLE,
  output logic EXTRA_OUTPUT_ENABLE,
  output logic PERIPH_DIRECT_XFER_STROBE,
  output logic [1:0] MEMORY_CLK_OUT,
  output logic [1:0] MEMORY_CLK_OE
);
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rmux;
  logic [8:0] ctrl_q;
  logic [31:0] addr_q;
  logic [63:0] wdata_q;
  logic [63:0] rcap_q;
  esh_pkg::esh_hold_e hold_q;
  esh_pkg::esh_op_e op_q;
  logic run_q;
  logic [3:0] cnt_q;
  logic pdt_q;
  logic pdt_on_q;
  logic sr_q;
  logic [2:0] pre_q;
  logic [1:0] tcnt_q;
  logic grant_n_q;
  logic bus_oe_q;
  logic [1:0] mclk_q;
  logic [1:0] mclk_oe_q;
  logic [3:0] ce_n_q;
  logic [7:0] be_n_q;
  logic [22:3] ea_q;
  logic [63:0] do_q;
  logic do_oe_q;
  esh_pkg::esh_strobe_s stb_q;
  logic cke_q;
  logic eoe_q;
  logic req;
  logic ok;
  logic accept;
  logic commit;
  logic start;
  logic tick;
  logic [2:0] div;
  logic [3:0] tgt;
  logic is_rd;
  logic is_wr;
  logic st_pdt;
  esh_pkg::esh_op_e new_op;

  // A request is answered one cycle after it is seen; a command waits while the
  // engine or the yield handshake is busy, which is how software is held off.
  assign req = AVS_READ | AVS_WRITE;
  assign ok = (AVS_ADDRESS != `ESH_CMD) || AVS_READ || (!run_q && hold_q == esh_pkg::H_IDLE);
  assign accept = req && wait_q && ok;
  assign commit = req && !wait_q;
  assign start = commit && AVS_WRITE && AVS_ADDRESS == `ESH_CMD;
  assign new_op = esh_pkg::esh_op_e'(AVS_WRITEDATA[`ESH_K_OP]);
  assign is_rd = new_op == esh_pkg::OP_READ;
  assign is_wr = new_op == esh_pkg::OP_WRITE;
  assign st_pdt = (is_rd && AVS_WRITEDATA[`ESH_K_DRS]) || (is_wr && AVS_WRITEDATA[`ESH_K_DWS]);

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    case (AVS_ADDRESS)
      `ESH_CTRL: rmux = {23'h000000, ctrl_q};
      `ESH_ADDR: rmux = addr_q;
      `ESH_WDLO: rmux = wdata_q[31:0];
      `ESH_WDHI: rmux = wdata_q[63:32];
      `ESH_STAT: rmux = {27'h0000000, sr_q, hold_q != esh_pkg::H_IDLE, !grant_n_q, !bus_oe_q, run_q};
      `ESH_RDLO: rmux = rcap_q[31:0];
      `ESH_RDHI: rmux = rcap_q[63:32];
      default: rmux = 32'h00000000;
    endcase
  end

  // Bus slave handshake.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= !accept;
      if (accept && AVS_READ) begin
        rdata_q <= rmux;
      end
    end
  end

  // Software registers take writes at the completing edge.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q <= `ESH_CTRL_RST;
      addr_q <= 32'h00000000;
      wdata_q <= 64'h0;
    end else if (commit && AVS_WRITE) begin
      case (AVS_ADDRESS)
        `ESH_CTRL: ctrl_q <= AVS_WRITEDATA[8:0];
        `ESH_ADDR: addr_q <= AVS_WRITEDATA;
        `ESH_WDLO: wdata_q[31:0] <= AVS_WRITEDATA;
        `ESH_WDHI: wdata_q[63:32] <= AVS_WRITEDATA;
        default: wdata_q <= wdata_q;
      endcase
    end
  end

  // Interface period source: every cycle, or divided by four or six.
  always_comb begin
    case (ctrl_q[`ESH_C_SRC])
      2'h1: div = `ESH_DIV4;
      2'h2: div = `ESH_DIV6;
      default: div = 3'h0;
    endcase
  end
  assign tick = pre_q == div;

  // The prescaler restarts on every tick, and stays cleared while idle or held. A request edge
  // therefore always starts a whole period, so a divided source cannot shorten the float or resume minimum.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pre_q <= 3'h0;
    end else if (tick || (hold_q == esh_pkg::H_IDLE) || (hold_q == esh_pkg::H_HELD)) begin
      pre_q <= 3'h0;
    end else begin
      pre_q <= pre_q + 3'h1;
    end
  end

  // Bus yield handshake.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      hold_q <= esh_pkg::H_IDLE;
      tcnt_q <= 2'h0;
      grant_n_q <= 1'b1;
      bus_oe_q <= 1'b1;
      mclk_oe_q <= 2'h3;
    end else begin
      case (hold_q)
        esh_pkg::H_IDLE: begin
          tcnt_q <= 2'h0;
          if (!BUS_YIELD_REQ_N) begin
            hold_q <= esh_pkg::H_WAIT;
          end
        end
        esh_pkg::H_WAIT: begin
          if (BUS_YIELD_REQ_N) begin
            hold_q <= esh_pkg::H_IDLE;
          end else if (tcnt_q != `ESH_FLOAT_E) begin
            tcnt_q <= tcnt_q + {1'b0, tick};
          end else if (!run_q && !ctrl_q[`ESH_C_BLK]) begin
            bus_oe_q <= 1'b0;
            mclk_oe_q <= ~ctrl_q[`ESH_C_KHZ];
            hold_q <= esh_pkg::H_FLOAT;
          end
        end
        esh_pkg::H_FLOAT: begin
          tcnt_q <= 2'h0;
          if (tick) begin
            grant_n_q <= 1'b0;
            hold_q <= esh_pkg::H_HELD;
          end
        end
        esh_pkg::H_HELD: begin
          if (BUS_YIELD_REQ_N) begin
            hold_q <= esh_pkg::H_RESUME;
          end
        end
        esh_pkg::H_RESUME: begin
          if (tcnt_q != `ESH_RESUME_E) begin
            tcnt_q <= tcnt_q + {1'b0, tick};
          end else begin
            bus_oe_q <= 1'b1;
            mclk_oe_q <= 2'h3;
            hold_q <= esh_pkg::H_REGRANT;
          end
        end
        esh_pkg::H_REGRANT: begin
          if (tick) begin
            grant_n_q <= 1'b1;
            hold_q <= esh_pkg::H_IDLE;
          end
        end
        default: hold_q <= esh_pkg::H_IDLE;
      endcase
    end
  end

  // Memory clocks run at half the core rate and never stop, even while yielded.
  for (genvar k = 0; k < 2; k++) begin : g_mclk
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
        mclk_q[k] <= 1'b0;
      end else begin
        mclk_q[k] <= !mclk_q[k];
      end
    end
  end

  // Command engine: a read or write runs eight cycles so the latest strobe fits.
  assign tgt = (op_q == esh_pkg::OP_READ) ? `ESH_CAS_LAT + {2'h0, ctrl_q[`ESH_C_RL]}
                                          : {2'h0, ctrl_q[`ESH_C_WL]};
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_q <= 1'b0;
      cnt_q <= 4'h0;
      op_q <= esh_pkg::OP_NOP;
      pdt_on_q <= 1'b0;
    end else if (start) begin
      run_q <= is_rd || is_wr;
      cnt_q <= 4'h0;
      op_q <= new_op;
      pdt_on_q <= st_pdt;
    end else if (run_q) begin
      cnt_q <= cnt_q + 4'h1;
      run_q <= cnt_q != `ESH_RUN_LAST;
    end
  end

  // Strobe truth table, registered so the pins change only on the clock.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      stb_q <= 3'h7;
      ce_n_q <= 4'hf;
      be_n_q <= 8'hff;
      ea_q <= 20'h00000;
      cke_q <= 1'b1;
      eoe_q <= 1'b1;
      sr_q <= 1'b0;
    end else if (start) begin
      ce_n_q <= ~(4'h1 << AVS_WRITEDATA[`ESH_K_CE]);
      be_n_q <= ~AVS_WRITEDATA[`ESH_K_BE];
      ea_q <= addr_q[19:0];
      eoe_q <= 1'b1;
      case (new_op)
        esh_pkg::OP_ROW_ACTIVATE_CMD: stb_q <= 3'h3;
        esh_pkg::OP_READ: stb_q <= 3'h5;
        esh_pkg::OP_WRITE: stb_q <= 3'h4;
        esh_pkg::OP_PRECHARGE_ALL_CMD: begin
          stb_q <= 3'h2;
          ea_q[13] <= 1'b1;
        end
        esh_pkg::OP_BANK_DEACTIVATE_CMD: begin
          stb_q <= 3'h2;
          ea_q[13] <= 1'b0;
        end
        esh_pkg::OP_AUTO_REFRESH_CMD: stb_q <= 3'h1;
        esh_pkg::OP_MRS: stb_q <= 3'h0;
        esh_pkg::OP_SRE: begin
          stb_q <= 3'h1;
          cke_q <= 1'b0;
          sr_q <= 1'b1;
        end
        esh_pkg::OP_SRX: begin
          cke_q <= 1'b1;
          sr_q <= 1'b0;
        end
        default: stb_q <= 3'h7;
      endcase
    end else begin
      stb_q <= 3'h7;
      if (!run_q) begin
        ce_n_q <= 4'hf;
        be_n_q <= 8'hff;
      end
    end
  end

  // Write data drives only cycle 0, and never for a direct transfer write.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      do_q <= 64'h0;
      do_oe_q <= 1'b0;
    end else begin
      do_q <= wdata_q;
      do_oe_q <= start && is_wr && !st_pdt;
    end
  end

  // Read data is taken in the data phase unless it goes straight to a peripheral.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rcap_q <= 64'h0;
    end else if (run_q && op_q == esh_pkg::OP_READ && cnt_q == `ESH_CAS_LAT && !pdt_on_q) begin
      rcap_q <= EXT_DATA_BUS_I;
    end
  end

  // Direct transfer strobe lands latency cycles after the data phase.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pdt_q <= 1'b0;
    end else if (start) begin
      pdt_q <= st_pdt && is_wr && AVS_WRITEDATA[`ESH_K_DWS] && ctrl_q[`ESH_C_WL] == 2'h0;
    end else begin
      pdt_q <= run_q && pdt_on_q && (cnt_q + 4'h1 == tgt);
    end
  end

  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign BUS_YIELD_GRANT_N = grant_n_q;
  assign EXT_BUS_OE = bus_oe_q;
  assign CHIP_ENABLE_N = ce_n_q;
  assign BYTE_ENABLE_N = be_n_q;
  assign EXT_ADDR_BUS = ea_q;
  assign EXT_DATA_BUS_O = do_q;
  assign EXT_DATA_BUS_OE = do_oe_q;
  assign SDRAM_STROBES = stb_q;
  assign SDRAM_CLK_ENABLE = cke_q;
  assign EXTRA_OUTPUT_ENABLE = eoe_q;
  assign PERIPH_DIRECT_XFER_STROBE = pdt_q;
  assign MEMORY_CLK_OUT = mclk_q;
  assign MEMORY_CLK_OE = mclk_oe_q;

  // Helper counts of cycles since the request last changed.
  logic [7:0] lo_cnt;
  logic [7:0] hi_cnt;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      lo_cnt <= 8'h00;
      hi_cnt <= 8'h00;
    end else begin
      lo_cnt <= BUS_YIELD_REQ_N ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hff};
      hi_cnt <= !BUS_YIELD_REQ_N ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hff};
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  property p_strobe_read;
    start && is_rd |=> SDRAM_STROBES == 3'h5 ##1 SDRAM_STROBES == 3'h7;
  endproperty
  a_strobe_read: assert property (p_strobe_read) else $error("read strobes wrong");
  property p_pdt_cause;
    PERIPH_DIRECT_XFER_STROBE |-> $past(st_pdt && start) || pdt_on_q;
  endproperty
  a_pdt_cause: assert property (p_pdt_cause) else $error("direct strobe without direct mode");
  property p_no_capture;
    run_q && pdt_on_q |=> $stable(rcap_q);
  endproperty
  a_no_capture: assert property (p_no_capture) else $error("direct read captured data");
  property p_hiz;
    pdt_on_q |-> !EXT_DATA_BUS_OE;
  endproperty
  a_hiz: assert property (p_hiz) else $error("direct write drove data");
  property p_rd_lat;
    start && st_pdt && is_rd && AVS_WRITEDATA[`ESH_K_DRS] && ctrl_q[`ESH_C_RL] == 2'h2 |-> ##6 PERIPH_DIRECT_XFER_STROBE;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read strobe latency wrong");
  property p_float_min;
    $fell(EXT_BUS_OE) |-> lo_cnt >= 8'h02;
  endproperty
  a_float_min: assert property (p_float_min) else $error("bus floated too early");
  property p_grant;
    $fell(EXT_BUS_OE) |-> ##[1:12] !BUS_YIELD_GRANT_N;
  endproperty
  a_grant: assert property (p_grant) else $error("grant late");
  property p_resume;
    $rose(EXT_BUS_OE) |-> hi_cnt >= 8'h02 && hi_cnt <= 8'h2a;
  endproperty
  a_resume: assert property (p_resume) else $error("resume out of window");
  property p_regrant;
    $rose(EXT_BUS_OE) |-> ##[1:12] BUS_YIELD_GRANT_N;
  endproperty
  a_regrant: assert property (p_regrant) else $error("grant release late");
  property p_block;
    ctrl_q[`ESH_C_BLK] && hold_q != esh_pkg::H_FLOAT && BUS_YIELD_GRANT_N |=> BUS_YIELD_GRANT_N;
  endproperty
  a_block: assert property (p_block) else $error("granted while blocked");
  property p_pend;
    !BUS_YIELD_GRANT_N |-> !run_q && (!EXT_BUS_OE || hold_q == esh_pkg::H_REGRANT);
  endproperty
  a_pend: assert property (p_pend) else $error("granted with bus busy");
  property p_clk_run;
    ctrl_q[5] == 1'b0 |-> MEMORY_CLK_OE[0];
  endproperty
  a_clk_run: assert property (p_clk_run) else $error("clock floated when not selected");
  c_grant: cover property (!BUS_YIELD_GRANT_N ##[1:40] BUS_YIELD_GRANT_N);
  c_pdt: cover property (PERIPH_DIRECT_XFER_STROBE);
  c_sr: cover property ($fell(SDRAM_CLK_ENABLE));
endmodule
`default_nettype wire

// >>> esh_sdram_model.sv
`default_nettype none
module esh_sdram_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire esh_pkg::esh_strobe_s strobes,
  input wire logic [3:0] ce_n,
  input wire logic [63:0] data_o,
  input wire logic data_oe,
  output logic [63:0] data_i,
  output logic [63:0] stored
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] age_q;
  logic rd_q;
  // A selected write command stores the word that the controller drives.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stored <= 64'h0;
    end else if (ce_n != 4'hf && strobes == 3'b100 && data_oe) begin
      stored <= data_o;
    end
  end
  // A selected read command starts the latency count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      age_q <= 3'h0;
    end else if (ce_n != 4'hf && strobes == 3'b101) begin
      rd_q <= 1'b1;
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  // The word shows only in the third cycle after a read command, as with a CAS latency of three.
  // The inverse elsewhere exposes a capture that is even one cycle early or late.
  assign data_i = (rd_q && age_q == 3'h2) ? stored : ~stored;
endmodule
`default_nettype wire

// >>> test_ext_mem_sdram_hold_pdt.sv
`include "esh_defs.svh"
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module test_ext_mem_sdram_hold_pdt;
  timeunit 1ns;
  timeprecision 100ps;
  logic CORE_CLK, RST_B, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, BUS_YIELD_REQ_N, BUS_YIELD_GRANT_N;
  logic EXT_BUS_OE, EXT_DATA_BUS_OE, SDRAM_CLK_ENABLE, EXTRA_OUTPUT_ENABLE, PERIPH_DIRECT_XFER_STROBE;
  logic [4:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
  logic [3:0] CHIP_ENABLE_N;
  logic [7:0] BYTE_ENABLE_N, cmd_b;
  logic [22:3] EXT_ADDR_BUS, cmd_a;
  logic [63:0] EXT_DATA_BUS_I, EXT_DATA_BUS_O, stored;
  logic [1:0] MEMORY_CLK_OUT, MEMORY_CLK_OE;
  esh_pkg::esh_strobe_s SDRAM_STROBES, cmd_s;
  logic boe_q, gnt_q, ce_idle;
  int fail_count, num_checks, cyc, cmd_c, pdt_c, pdt_n, oe_n, fall_c, rise_c, gf_c, gr_c;
  esh_top esh_top_i (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .BUS_YIELD_REQ_N(BUS_YIELD_REQ_N), .BUS_YIELD_GRANT_N(BUS_YIELD_GRANT_N),
    .EXT_BUS_OE(EXT_BUS_OE), .CHIP_ENABLE_N(CHIP_ENABLE_N), .BYTE_ENABLE_N(BYTE_ENABLE_N),
    .EXT_ADDR_BUS(EXT_ADDR_BUS), .EXT_DATA_BUS_I(EXT_DATA_BUS_I), .EXT_DATA_BUS_O(EXT_DATA_BUS_O),
    .EXT_DATA_BUS_OE(EXT_DATA_BUS_OE), .SDRAM_STROBES(SDRAM_STROBES), .SDRAM_CLK_ENABLE(SDRAM_CLK_ENABLE),
    .EXTRA_OUTPUT_ENABLE(EXTRA_OUTPUT_ENABLE), .PERIPH_DIRECT_XFER_STROBE(PERIPH_DIRECT_XFER_STROBE),
    .MEMORY_CLK_OUT(MEMORY_CLK_OUT), .MEMORY_CLK_OE(MEMORY_CLK_OE));
  esh_sdram_model esh_sdram_model_i (.clk(CORE_CLK), .rst_n(RST_B), .strobes(SDRAM_STROBES),
    .ce_n(CHIP_ENABLE_N), .data_o(EXT_DATA_BUS_O), .data_oe(EXT_DATA_BUS_OE), .data_i(EXT_DATA_BUS_I),
    .stored(stored));
  // Clock at 40 MHz.
  initial begin
    CORE_CLK = 1'b0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end
  // Monitor that timestamps commands, strobes and yield edges in core cycles.
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (SDRAM_STROBES !== 3'b111) begin
      cmd_s <= SDRAM_STROBES;
      cmd_a <= EXT_ADDR_BUS;
      cmd_b <= BYTE_ENABLE_N;
      cmd_c <= cyc;
    end
    if (PERIPH_DIRECT_XFER_STROBE === 1'b1) begin
      pdt_c <= cyc;
      pdt_n <= pdt_n + 1;
    end
    if (EXT_DATA_BUS_OE === 1'b1) oe_n <= oe_n + 1;
    if (boe_q === 1'b1 && EXT_BUS_OE === 1'b0) begin
      fall_c <= cyc;
      // Chip enables must already be released in the cycle in which the bus floats.
      ce_idle <= (CHIP_ENABLE_N === 4'hf);
    end
    if (boe_q === 1'b0 && EXT_BUS_OE === 1'b1) rise_c <= cyc;
    if (gnt_q === 1'b1 && BUS_YIELD_GRANT_N === 1'b0) gf_c <= cyc;
    if (gnt_q === 1'b0 && BUS_YIELD_GRANT_N === 1'b1) gr_c <= cyc;
    boe_q <= EXT_BUS_OE;
    gnt_q <= BUS_YIELD_GRANT_N;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One bus cycle; the request stands until waitrequest is seen low at a rising edge.
  // Read data is taken at that same edge, and only then is the request dropped.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= wd;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 2000);
    `CHK("waitrequest", 1'b0, AVS_WAITREQUEST)
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  // Command word with all byte lanes on and chip select zero, then time for the run to end.
  task automatic cmd(input logic [3:0] op, input logic drs, input logic dws);
    bus(1'b1, `ESH_CMD, {16'h0, 8'hff, 2'h0, dws, drs, op});
    repeat (12) @(posedge CORE_CLK);
  endtask
  task automatic t_regs();
    `CHK("grant idle", 1'b1, BUS_YIELD_GRANT_N)
    `CHK("strobes idle", 3'b111, SDRAM_STROBES)
    `CHK("extra oe idle", 1'b1, EXTRA_OUTPUT_ENABLE)
    bus(1'b0, `ESH_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0, rd)
    bus(1'b0, 5'h1e, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b1, `ESH_CTRL, 32'h0000_017f);
    bus(1'b0, `ESH_CTRL, 32'h0);
    `CHK("ctrl rw", 32'h0000_017f, rd)
    bus(1'b1, `ESH_CTRL, 32'h0);
  endtask
  // Every plain command and its strobe pattern, plus the all-bank address flag.
  task automatic t_cmds();
    logic [3:0] ops [5];
    logic [2:0] pat [5];
    ops = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h7};
    pat = '{3'b011, 3'b010, 3'b010, 3'b001, 3'b000};
    bus(1'b1, `ESH_ADDR, 32'h0);
    for (int i = 0; i < 5; i++) begin
      cmd(ops[i], 1'b0, 1'b0);
      `CHK("command strobes", pat[i], cmd_s)
      if (i == 1 || i == 2) `CHK("all bank flag", i == 1, cmd_a[13])
    end
    cmd(esh_pkg::OP_SRE, 1'b0, 1'b0);
    `CHK("self refresh strobes", 3'b001, cmd_s)
    `CHK("cke in self refresh", 1'b0, SDRAM_CLK_ENABLE)
    cmd(esh_pkg::OP_SRX, 1'b0, 1'b0);
    `CHK("cke after exit", 1'b1, SDRAM_CLK_ENABLE)
  endtask
  // Plain write and read, then direct transfers at every latency code.
  task automatic t_data();
    int p0, o0;
    bus(1'b1, `ESH_WDLO, 32'h89ab_cdef);
    bus(1'b1, `ESH_WDHI, 32'h0123_4567);
    o0 = oe_n;
    cmd(esh_pkg::OP_WRITE, 1'b0, 1'b0);
    `CHK("write strobes", 3'b100, cmd_s)
    `CHK("stored word", 64'h0123_4567_89ab_cdef, stored)
    `CHK("data driven", 1, oe_n - o0)
    `CHK("byte lanes on", 8'h00, cmd_b)
    `CHK("byte lanes off", 8'hff, BYTE_ENABLE_N)
    p0 = pdt_n;
    cmd(esh_pkg::OP_READ, 1'b0, 1'b0);
    `CHK("read strobes", 3'b101, cmd_s)
    `CHK("no strobe plain", 0, pdt_n - p0)
    bus(1'b0, `ESH_RDHI, 32'h0);
    `CHK("read high", 32'h0123_4567, rd)
    bus(1'b1, `ESH_WDLO, 32'h5a5a_0f0f);
    cmd(esh_pkg::OP_WRITE, 1'b0, 1'b0);
    for (int l = 0; l < 4; l++) begin
      bus(1'b1, `ESH_CTRL, 32'(l));
      p0 = pdt_n;
      cmd(esh_pkg::OP_READ, 1'b1, 1'b0);
      `CHK("direct read pulses", 1, pdt_n - p0)
      `CHK("read latency", 3 + l, pdt_c - cmd_c)
      bus(1'b0, `ESH_RDLO, 32'h0);
      `CHK("no capture", 32'h89ab_cdef, rd)
      bus(1'b1, `ESH_CTRL, 32'(l << 2));
      o0 = oe_n;
      cmd(esh_pkg::OP_WRITE, 1'b0, 1'b1);
      `CHK("write latency", l, pdt_c - cmd_c)
      `CHK("data undriven", 0, oe_n - o0)
    end
  endtask
  // Yield handshake with a given source and clock float choice, optionally behind a read run.
  task automatic t_yield(input logic [1:0] src, input logic [1:0] khz, input logic busy);
    int e, r, n, j;
    e = (src == 2'h0) ? 1 : (src == 2'h1) ? 4 : 6;
    j = khz[0];
    bus(1'b1, `ESH_CTRL, {23'h0, src, khz, 5'h0});
    if (busy) bus(1'b1, `ESH_CMD, {16'h0, 8'hff, 4'h0, esh_pkg::OP_READ});
    @(posedge CORE_CLK);
    BUS_YIELD_REQ_N <= 1'b0;
    r = cyc;
    n = 0;
    while (BUS_YIELD_GRANT_N !== 1'b0 && n < 400) begin
      @(negedge CORE_CLK);
      n++;
    end
    repeat (2) @(negedge CORE_CLK);
    `CHK("granted", 1'b0, BUS_YIELD_GRANT_N)
    // The monitor sees an output edge one cycle after it moves, hence the minus one.
    `CHK("float min", 1, fall_c - r - 1 >= 2 * e)
    `CHK("grant after float", 1, gf_c >= fall_c && gf_c - fall_c <= 2 * e)
    `CHK("run finished first", 1'b1, ce_idle)
    `CHK("bus floated", 1'b0, EXT_BUS_OE)
    `CHK("clock float", ~khz, MEMORY_CLK_OE)
    r = MEMORY_CLK_OUT[j];
    @(negedge CORE_CLK);
    `CHK("clock toggles", !r[0], MEMORY_CLK_OUT[j])
    repeat (e) @(posedge CORE_CLK);
    BUS_YIELD_REQ_N <= 1'b1;
    r = cyc;
    n = 0;
    while (BUS_YIELD_GRANT_N !== 1'b1 && n < 400) begin
      @(negedge CORE_CLK);
      n++;
    end
    repeat (2) @(negedge CORE_CLK);
    `CHK("released", 1'b1, BUS_YIELD_GRANT_N)
    `CHK("resume window", 1, rise_c - r - 1 >= 2 * e && rise_c - r - 1 <= 7 * e)
    `CHK("release after drive", 1, gr_c >= rise_c && gr_c - rise_c <= 2 * e)
    `CHK("clocks driven", 2'b11, MEMORY_CLK_OE)
  endtask
  task automatic t_block();
    bus(1'b1, `ESH_CTRL, 32'h0000_0010);
    @(posedge CORE_CLK);
    BUS_YIELD_REQ_N <= 1'b0;
    repeat (40) @(posedge CORE_CLK);
    `CHK("blocked grant", 1'b1, BUS_YIELD_GRANT_N)
    `CHK("blocked bus", 1'b1, EXT_BUS_OE)
    BUS_YIELD_REQ_N <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
  endtask
  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    #400000;
    fail_count++;
    test_done();
  end
  initial begin
    {fail_count, num_checks, cyc, cmd_c, pdt_c, pdt_n, oe_n, fall_c, rise_c, gf_c, gr_c} = '0;
    {boe_q, gnt_q, ce_idle, cmd_b, cmd_a, cmd_s} = '0;
    RST_B = 1'b0;
    AVS_ADDRESS = 5'h0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0;
    BUS_YIELD_REQ_N = 1'b1;
    repeat (5) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    t_regs();
    t_cmds();
    t_data();
    t_yield(2'h0, 2'b01, 1'b0);
    t_yield(2'h1, 2'b10, 1'b0);
    t_yield(2'h2, 2'b00, 1'b0);
    t_yield(2'h0, 2'b01, 1'b1);
    t_block();
    test_done();
  end
endmodule
`default_nettype wire
